// *** verilog/ebw_pkg.sv ***
// package: codes, field layouts, reset values and carriers of the border and ram window decoder
package ebw_pkg;
  // command codes
  localparam logic [7:0] CMD_BORDER = 8'h3c;
  localparam logic [7:0] CMD_XWIN = 8'h44;
  localparam logic [7:0] CMD_YWIN = 8'h45;
  localparam logic [7:0] CMD_XCNT = 8'h4e;
  localparam logic [7:0] CMD_YCNT = 8'h4f;

  // border parameter byte field positions
  localparam int BRD_SRC_HI = 7;
  localparam int BRD_SRC_LO = 6;
  localparam int BRD_LVL_HI = 5;
  localparam int BRD_LVL_LO = 4;
  localparam int BRD_TBL_HI = 1;
  localparam int BRD_TBL_LO = 0;
  // border drive source encodings
  localparam logic [1:0] SRC_GRAYSCALE_TRANSITION = 2'h0;
  localparam logic [1:0] SRC_FIXED_LEVEL = 2'h1;
  localparam logic [1:0] SRC_COMMON_LEVEL = 2'h2;
  localparam logic [1:0] SRC_HIGH_IMPEDANCE = 2'h3;
  // fixed level encodings
  localparam logic [1:0] LVL_GROUND = 2'h0;
  localparam logic [1:0] LVL_POSITIVE_SOURCE_ONE = 2'h1;
  localparam logic [1:0] LVL_NEGATIVE_SOURCE = 2'h2;
  localparam logic [1:0] LVL_POSITIVE_SOURCE_TWO = 2'h3;
  // waveform table encodings
  localparam logic [1:0] TBL_WAVEFORM_ZERO = 2'h0;
  localparam logic [1:0] TBL_WAVEFORM_ONE = 2'h1;
  localparam logic [1:0] TBL_WAVEFORM_TWO = 2'h2;
  localparam logic [1:0] TBL_WAVEFORM_THREE = 2'h3;

  // address parameter fields
  localparam int X_MSB = 4;
  localparam int BIT8_POS = 0;

  // carriers
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] lvl;
    logic [1:0] tbl;
  } ebw_border_t;
  typedef struct packed {
    logic [4:0] xStart;
    logic [4:0] xEnd;
    logic [8:0] yStart;
    logic [8:0] yEnd;
  } ebw_win_t;
  typedef struct packed {
    logic [4:0] x;
    logic [8:0] y;
  } ebw_pos_t;
  typedef struct packed {
    logic isParam;
    logic [7:0] data;
  } ebw_byte_t;

  // reset values
  localparam ebw_border_t BORDER_RST = '{SRC_GRAYSCALE_TRANSITION, LVL_GROUND, TBL_WAVEFORM_ZERO};
  localparam logic [4:0] XS_RST = 5'h00;
  localparam logic [4:0] XE_RST = 5'h12;
  localparam logic [8:0] YS_RST = 9'h000;
  localparam logic [8:0] YE_RST = 9'h0f9;
  localparam logic [4:0] XC_RST = 5'h00;
  localparam logic [8:0] YC_RST = 9'h000;

  // parameter byte indices and last bit count
  localparam logic [2:0] P0 = 3'h0;
  localparam logic [2:0] P1 = 3'h1;
  localparam logic [2:0] P2 = 3'h2;
  localparam logic [2:0] P3 = 3'h3;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // register map, byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BORDER = 5'h04;
  localparam logic [4:0] REG_XWIN = 5'h08;
  localparam logic [4:0] REG_YWIN = 5'h0c;
  localparam logic [4:0] REG_XCNT = 5'h10;
  localparam logic [4:0] REG_YCNT = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  // register field positions and the enable reset value
  localparam int CTRL_EN_BIT = 0;
  localparam int XE_LSB = 8;
  localparam int YE_LSB = 16;
  localparam int ST_IDX_LSB = 8;
  localparam int ST_STATE_BIT = 16;
  localparam logic CTRL_EN_RST = 1'b1;

  typedef enum logic {DEC_IDLE, DEC_PARAM} ebw_dec_t;
endpackage

// *** verilog/ebw_sync2.sv ***
// file: two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module ebw_sync2 #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // level in and synchronised level out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      dout <= '0;
    end else if (clkEn) begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// *** verilog/ebw_cmd_decoder.sv ***
// file: serial command decoder for border drive, ram window and ram position settings
// Operation
// R1: command 3c takes the next parameter byte as the border drive configuration.
// R2: border bits 7:6 pick the source: transition table, fixed level, common level or high impedance.
// R3: border bits 5:4 pick the fixed level: ground, first positive, negative or second positive source level.
// R4: border bits 1:0 pick waveform table zero to three for the transition source.
// R5: command 44 takes two bytes whose low five bits are x start and x end.
// R6: after reset x start is 00 and x end is 12.
// R7: command 45 takes four bytes: y start low, y start bit 8, y end low, y end bit 8.
// R8: after reset y start is 00 and y end is f9.
// R9: command 4e loads the low five bits of its byte into the x position counter, reset 00.
// R10: command 4f loads a nine bit y position, low byte first then bit 8, reset 00.
// R11: bytes with select low are commands, bytes with select high are parameters of the last command in order.
// R12: the host writes unused parameter bits as zero.
`timescale 1ns/100ps
`default_nettype none
module ebw_cmd_decoder (
  // system clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // serial link pins
  input wire logic sclk,
  input wire logic csN,
  input wire logic dcSel,
  input wire logic sda,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // settings outputs
  output ebw_pkg::ebw_border_t borderCfg,
  output ebw_pkg::ebw_win_t ramWindow,
  output ebw_pkg::ebw_pos_t ramPos
);
  import ebw_pkg::*;

  logic linkClr;
  logic [2:0] bitCnt_ff;
  logic [6:0] shift_ff;
  ebw_byte_t linkWord_ff;
  logic linkTgl_ff;
  logic tglSync;
  logic tglSeen_ff;
  ebw_byte_t rxWord_ff;
  logic rxVld_ff;
  logic ctrlEn_ff;
  ebw_dec_t decState_ff;
  logic [7:0] cmd_ff;
  logic [2:0] idx_ff;
  logic paramAcc;
  logic busWr;
  logic [31:0] nxt_readData;

  // link side: frame ends clear the bit count, sclk need not run outside frames
  assign linkClr = ~arst_n | csN;

  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      bitCnt_ff <= 3'h0;
      shift_ff <= 7'h00;
    end else begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
      shift_ff <= {shift_ff[5:0], sda};
    end
  end

  // byte complete: hold it and toggle, the word stays stable for eight sclk periods
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      linkWord_ff <= '0;
      linkTgl_ff <= 1'b0;
    end else if (bitCnt_ff == BIT_LAST) begin
      linkWord_ff <= '{dcSel, {shift_ff, sda}}; // R11
      linkTgl_ff <= ~linkTgl_ff;
    end
  end

  // toggle crosses into the system clock
  ebw_sync2 #(.W(1)) uTglSync (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .din(linkTgl_ff),
    .dout(tglSync)
  );

  // capture the byte once its toggle is seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tglSeen_ff <= 1'b0;
      rxWord_ff <= '0;
      rxVld_ff <= 1'b0;
    end else if (clkEn) begin
      tglSeen_ff <= tglSync;
      rxVld_ff <= tglSync != tglSeen_ff;
      if (tglSync != tglSeen_ff) begin
        rxWord_ff <= linkWord_ff;
      end
    end
  end

  // command tracking; parameters with no command before them are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decState_ff <= DEC_IDLE;
      cmd_ff <= 8'h00;
      idx_ff <= P0;
    end else if (clkEn && rxVld_ff && ctrlEn_ff) begin
      case (decState_ff)
        DEC_IDLE: begin
          if (!rxWord_ff.isParam) begin
            decState_ff <= DEC_PARAM; // R11
            cmd_ff <= rxWord_ff.data;
            idx_ff <= P0;
          end
        end
        DEC_PARAM: begin
          if (!rxWord_ff.isParam) begin
            cmd_ff <= rxWord_ff.data; // R11
            idx_ff <= P0;
          end else if (idx_ff != IDX_MAX) begin
            idx_ff <= idx_ff + 3'h1; // R11
          end
        end
        default: begin
          decState_ff <= DEC_IDLE;
        end
      endcase
    end
  end

  assign paramAcc = clkEn && rxVld_ff && ctrlEn_ff && rxWord_ff.isParam && decState_ff == DEC_PARAM;
  assign busWr = clkEn && avs_write && !avs_waitrequest;

  // control register: decoder enable, cleared stops serial bytes from acting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlEn_ff <= CTRL_EN_RST;
    end else if (busWr && avs_address == REG_CTRL) begin
      ctrlEn_ff <= avs_writedata[CTRL_EN_BIT];
    end
  end

  // border configuration; serial parameter wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      borderCfg <= BORDER_RST; // R2 R3 R4
    end else if (paramAcc && cmd_ff == CMD_BORDER && idx_ff == P0) begin
      borderCfg.src <= rxWord_ff.data[BRD_SRC_HI:BRD_SRC_LO]; // R1 R2
      borderCfg.lvl <= rxWord_ff.data[BRD_LVL_HI:BRD_LVL_LO]; // R3
      borderCfg.tbl <= rxWord_ff.data[BRD_TBL_HI:BRD_TBL_LO]; // R4
    end else if (busWr && avs_address == REG_BORDER) begin
      borderCfg.src <= avs_writedata[BRD_SRC_HI:BRD_SRC_LO];
      borderCfg.lvl <= avs_writedata[BRD_LVL_HI:BRD_LVL_LO];
      borderCfg.tbl <= avs_writedata[BRD_TBL_HI:BRD_TBL_LO];
    end
  end

  // ram window; upper bits of the x and bit 8 bytes are discarded, so nonzero fill does no harm
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramWindow.xStart <= XS_RST; // R6
      ramWindow.xEnd <= XE_RST; // R6
      ramWindow.yStart <= YS_RST; // R8
      ramWindow.yEnd <= YE_RST; // R8
    end else if (paramAcc && cmd_ff == CMD_XWIN) begin
      if (idx_ff == P0) begin
        ramWindow.xStart <= rxWord_ff.data[X_MSB:0]; // R5
      end else if (idx_ff == P1) begin
        ramWindow.xEnd <= rxWord_ff.data[X_MSB:0]; // R5
      end
    end else if (paramAcc && cmd_ff == CMD_YWIN) begin
      case (idx_ff)
        P0: ramWindow.yStart[7:0] <= rxWord_ff.data; // R7
        P1: ramWindow.yStart[8] <= rxWord_ff.data[BIT8_POS]; // R7
        P2: ramWindow.yEnd[7:0] <= rxWord_ff.data; // R7
        P3: ramWindow.yEnd[8] <= rxWord_ff.data[BIT8_POS]; // R7
        default: ramWindow.yEnd <= ramWindow.yEnd;
      endcase
    end else if (busWr && avs_address == REG_XWIN) begin
      ramWindow.xStart <= avs_writedata[X_MSB:0];
      ramWindow.xEnd <= avs_writedata[XE_LSB+X_MSB:XE_LSB];
    end else if (busWr && avs_address == REG_YWIN) begin
      ramWindow.yStart <= avs_writedata[8:0];
      ramWindow.yEnd <= avs_writedata[YE_LSB+8:YE_LSB];
    end
  end

  // ram position counter initial values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramPos.x <= XC_RST; // R9
      ramPos.y <= YC_RST; // R10
    end else if (paramAcc && cmd_ff == CMD_XCNT && idx_ff == P0) begin
      ramPos.x <= rxWord_ff.data[X_MSB:0]; // R9
    end else if (paramAcc && cmd_ff == CMD_YCNT && idx_ff == P0) begin
      ramPos.y[7:0] <= rxWord_ff.data; // R10
    end else if (paramAcc && cmd_ff == CMD_YCNT && idx_ff == P1) begin
      ramPos.y[8] <= rxWord_ff.data[BIT8_POS]; // R10
    end else if (busWr && avs_address == REG_XCNT) begin
      ramPos.x <= avs_writedata[X_MSB:0];
    end else if (busWr && avs_address == REG_YCNT) begin
      ramPos.y <= avs_writedata[8:0];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_readData = 32'h0000_0000;
    case (avs_address)
      REG_CTRL: nxt_readData[CTRL_EN_BIT] = ctrlEn_ff;
      REG_BORDER: begin
        nxt_readData[BRD_SRC_HI:BRD_SRC_LO] = borderCfg.src;
        nxt_readData[BRD_LVL_HI:BRD_LVL_LO] = borderCfg.lvl;
        nxt_readData[BRD_TBL_HI:BRD_TBL_LO] = borderCfg.tbl;
      end
      REG_XWIN: begin
        nxt_readData[X_MSB:0] = ramWindow.xStart;
        nxt_readData[XE_LSB+X_MSB:XE_LSB] = ramWindow.xEnd;
      end
      REG_YWIN: begin
        nxt_readData[8:0] = ramWindow.yStart;
        nxt_readData[YE_LSB+8:YE_LSB] = ramWindow.yEnd;
      end
      REG_XCNT: nxt_readData[X_MSB:0] = ramPos.x;
      REG_YCNT: nxt_readData[8:0] = ramPos.y;
      REG_STATUS: begin
        nxt_readData[7:0] = cmd_ff;
        nxt_readData[ST_IDX_LSB+2:ST_IDX_LSB] = idx_ff;
        nxt_readData[ST_STATE_BIT] = decState_ff == DEC_PARAM;
      end
      default: nxt_readData = 32'h0000_0000;
    endcase
  end

  // bus handshake: idle high, one low cycle per request, write commits on that low cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clkEn) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= nxt_readData;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // checks
  a_border_src_latch: assert property (@(posedge clk) disable iff (!arst_n) // R2
    paramAcc && cmd_ff == CMD_BORDER && idx_ff == P0
    |=> borderCfg.src == $past(rxWord_ff.data[BRD_SRC_HI:BRD_SRC_LO]))
    else $error("border source not taken from parameter");
  a_border_lvl_tbl: assert property (@(posedge clk) disable iff (!arst_n) // R3
    paramAcc && cmd_ff == CMD_BORDER && idx_ff == P0
    |=> borderCfg.lvl == $past(rxWord_ff.data[BRD_LVL_HI:BRD_LVL_LO])
        && borderCfg.tbl == $past(rxWord_ff.data[BRD_TBL_HI:BRD_TBL_LO]))
    else $error("border level or table not taken from parameter");
  a_xwin_start_load: assert property (@(posedge clk) disable iff (!arst_n) // R5
    paramAcc && cmd_ff == CMD_XWIN && idx_ff == P0
    |=> ramWindow.xStart == $past(rxWord_ff.data[X_MSB:0]) && $stable(ramWindow.xEnd))
    else $error("x window start not loaded from first byte");
  a_ywin_start_lo: assert property (@(posedge clk) disable iff (!arst_n) // R7
    paramAcc && cmd_ff == CMD_YWIN && idx_ff == P0
    |=> ramWindow.yStart[7:0] == $past(rxWord_ff.data) && $stable(ramWindow.yEnd))
    else $error("y window start low byte not loaded from first byte");
  a_xwin_end_load: assert property (@(posedge clk) disable iff (!arst_n) // R5
    paramAcc && cmd_ff == CMD_XWIN && idx_ff == P1
    |=> ramWindow.xEnd == $past(rxWord_ff.data[X_MSB:0]) && $stable(ramWindow.xStart))
    else $error("x window end not loaded from second byte");
  a_ywin_end_hi: assert property (@(posedge clk) disable iff (!arst_n) // R7
    paramAcc && cmd_ff == CMD_YWIN && idx_ff == P3
    |=> ramWindow.yEnd[8] == $past(rxWord_ff.data[BIT8_POS]) && $stable(ramWindow.yEnd[7:0]))
    else $error("y window end bit 8 not loaded from fourth byte");
  a_xpos_load: assert property (@(posedge clk) disable iff (!arst_n) // R9
    paramAcc && cmd_ff == CMD_XCNT && idx_ff == P0 |=> ramPos.x == $past(rxWord_ff.data[X_MSB:0]))
    else $error("x position not loaded");
  a_ypos_low: assert property (@(posedge clk) disable iff (!arst_n) // R10
    paramAcc && cmd_ff == CMD_YCNT && idx_ff == P0
    |=> ramPos.y[7:0] == $past(rxWord_ff.data) && $stable(ramPos.x))
    else $error("y position low byte not loaded from first byte");
  a_ypos_pair: assert property (@(posedge clk) disable iff (!arst_n) // R10
    paramAcc && cmd_ff == CMD_YCNT && idx_ff == P1
    |=> ramPos.y[8] == $past(rxWord_ff.data[BIT8_POS]) && $stable(ramPos.y[7:0]))
    else $error("y position bit 8 not loaded from second byte");
  a_cmd_restart: assert property (@(posedge clk) disable iff (!arst_n) // R11
    clkEn && rxVld_ff && ctrlEn_ff && !rxWord_ff.isParam
    |=> cmd_ff == $past(rxWord_ff.data) && idx_ff == P0 && decState_ff == DEC_PARAM)
    else $error("command byte did not restart parameter order");
  a_param_order: assert property (@(posedge clk) disable iff (!arst_n) // R11
    paramAcc && idx_ff != IDX_MAX |=> idx_ff == $past(idx_ff) + 3'h1)
    else $error("parameter index did not advance");
  a_bus_one_wait: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && (avs_read || avs_write) && avs_waitrequest ##1 clkEn |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_window_idle: assert property (@(posedge clk) disable iff (!arst_n) // R5 R7
    !paramAcc && !busWr |=> $stable(ramWindow))
    else $error("window changed with no write");
endmodule
`default_nettype wire

// *** dv/ebw_host_model.sv ***
// file: behavioural host driving the serial command link
`timescale 1ns/100ps
`default_nettype none
module ebw_host_model (
  // serial link pins driven by the host
  output logic sclk,
  output logic csN,
  output logic dcSel,
  output logic sda
);
  // link clock stands still low between frames
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dcSel = 1'b0;
    sda = 1'b0;
  end

  // msb first on an 80 ns link clock, select held over the whole byte
  task automatic sendBits(input logic [7:0] b, input logic dc, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      sda = b[i];
      dcSel = dc;
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask

  // released lines flip so a stale level is never mistaken for data
  task automatic endFrame();
    #30 csN = 1'b1;
    sda = ~sda;
    dcSel = ~dcSel;
    #120;
  endtask

  // optional command byte then n parameter bytes, first one in the top byte; every bit of those bytes sent as given
  task automatic frame(input logic hasCmd, input logic [7:0] code, input int n, input logic [31:0] p);
    csN = 1'b0;
    #33;
    if (hasCmd) begin
      sendBits(code, 1'b0, 8);
    end
    for (int i = 0; i < n; i++) begin
      sendBits(p[31 - 8 * i -: 8], 1'b1, 8);
    end
    endFrame();
  endtask

  // partial byte cut short by chip select
  task automatic abortBits(input int nb);
    csN = 1'b0;
    #33;
    sendBits(8'hff, 1'b1, nb);
    endFrame();
  endtask
endmodule
`default_nettype wire

// *** dv/ebw_cmd_decoder_tb.sv ***
// file: self-checking bench for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
module ebw_cmd_decoder_tb;
  import ebw_pkg::*;
  // clock, reset, bus and link signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic clkEn = 1'b1;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic sclk, csN, dcSel, sda;
  ebw_border_t borderCfg;
  ebw_win_t ramWindow;
  ebw_pos_t ramPos;
  logic [31:0] rd;
  logic [1:0] s;
  int num_errors = 0;
  int total_checks = 0;

  // 50 MHz system clock
  always #10 clk = ~clk;

  ebw_cmd_decoder u_ebw_cmd_decoder (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .sclk(sclk), .csN(csN), .dcSel(dcSel), .sda(sda),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .borderCfg(borderCfg), .ramWindow(ramWindow), .ramPos(ramPos)
  );
  ebw_host_model u_ebw_host_model (.sclk(sclk), .csN(csN), .dcSel(dcSel), .sda(sda));

  // one compare for every kind of result, widened to 32 bits
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until waitrequest is seen low at an edge; read data taken there
  // no cycle limit here: a hung slave is caught by the watchdog
  task automatic avAccess(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge clk);
    end while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  // one frame, then time for the synchroniser and update to land
  task automatic send(input logic hasCmd, input logic [7:0] code, input int n, input logic [31:0] p);
    u_ebw_host_model.frame(hasCmd, code, n, p);
    repeat (8) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog well past the roughly 28 us the tests need
  initial begin
    #400000;
    num_errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // defaults seen at the ports and through the bus
    check("borderCfg", 32'h0, 32'(borderCfg));
    check("ramWindow", {4'h0, 5'h00, 5'h12, 9'h000, 9'h0f9}, 32'(ramWindow));
    check("ramPos", 32'h0, 32'(ramPos));
    avAccess(1'b0, REG_XWIN, 32'h0);
    check("xwinReg", 32'h00001200, rd);
    avAccess(1'b0, REG_YWIN, 32'h0);
    check("ywinReg", 32'h00f90000, rd);
    // every source, level and table code once
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      send(1'b1, CMD_BORDER, 1, {s, ~s, 2'b00, s ^ 2'h1, 24'h000000});
      check("borderCfg", 32'({s, ~s, s ^ 2'h1}), 32'(borderCfg));
    end
    // windows at the top of the x range and above 255 in y
    send(1'b1, CMD_XWIN, 2, 32'h051f_0000);
    send(1'b1, CMD_YWIN, 4, 32'hab01_0001);
    check("ramWindow", {4'h0, 5'h05, 5'h1f, 9'h1ab, 9'h100}, 32'(ramWindow));
    avAccess(1'b0, REG_YWIN, 32'h0);
    check("ywinReg", 32'h010001ab, rd);
    // position counters, y parameter split over two frames
    send(1'b1, CMD_XCNT, 2, 32'h1309_0000);
    send(1'b1, CMD_YCNT, 1, 32'hff00_0000);
    send(1'b0, 8'h00, 1, 32'h0100_0000);
    check("ramPos", {18'h0, 5'h13, 9'h1ff}, 32'(ramPos));
    // unknown command swallows its parameters; cut byte is dropped
    send(1'b1, 8'h00, 1, 32'h0a00_0000);
    u_ebw_host_model.abortBits(5);
    send(1'b1, CMD_YCNT, 2, 32'h2200_0000);
    check("ramPos", {18'h0, 5'h13, 9'h022}, 32'(ramPos));
    // disabled decoder ignores serial bytes
    avAccess(1'b1, REG_CTRL, 32'h0);
    send(1'b1, CMD_BORDER, 1, 32'hc000_0000);
    check("borderCfg", 32'h32, 32'(borderCfg));
    avAccess(1'b1, REG_CTRL, 32'h1);
    // unmapped place: write dropped, read zero
    avAccess(1'b1, 5'h1c, 32'hffffffff);
    avAccess(1'b0, 5'h1c, 32'h0);
    check("unmapped", 32'h0, rd);
    // low clock enable holds a received parameter back until it rises again
    send(1'b1, CMD_XCNT, 0, 32'h0000_0000);
    clkEn <= 1'b0;
    send(1'b0, 8'h00, 1, 32'h0c00_0000);
    check("ramPos", {18'h0, 5'h13, 9'h022}, 32'(ramPos));
    clkEn <= 1'b1;
    repeat (8) @(posedge clk);
    check("ramPos", {18'h0, 5'h0c, 9'h022}, 32'(ramPos));
    // bus write reaches the counter port
    avAccess(1'b1, REG_XCNT, 32'h0000001e);
    @(posedge clk);
    check("ramPos", {18'h0, 5'h1e, 9'h022}, 32'(ramPos));
    // reset in mid-run brings every default back, and the link works after it
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check("borderCfg", 32'h0, 32'(borderCfg));
    check("ramWindow", {4'h0, 5'h00, 5'h12, 9'h000, 9'h0f9}, 32'(ramWindow));
    check("ramPos", 32'h0, 32'(ramPos));
    send(1'b1, CMD_XCNT, 1, 32'h0700_0000);
    check("ramPos", {18'h0, 5'h07, 9'h000}, 32'(ramPos));
    results();
  end
endmodule
`default_nettype wire
